// [rtl/ppip_pkg.sv]
package ppip_pkg;
    localparam int PPIP_DATA_W = 8;
    // Width of the next_byte_ack_n pulses toward the host, in ns
    localparam int PPIP_ACK_NS = 5000;
    localparam int PPIP_CLK_NS = 10;
    localparam int PPIP_ACK_CYC = (PPIP_ACK_NS + PPIP_CLK_NS - 1) / PPIP_CLK_NS;
    localparam int PPIP_CNT_W = 10;
    localparam logic [7:0] PPIP_DATA_RST = 8'h00;

    typedef enum logic [1:0] {
        PPIP_IDLE,
        PPIP_FULL,
        PPIP_ACK
    } ppip_state_e;
endpackage

// [rtl/ppip_edge.sv]
// Falling-edge detector; the input is already synchronous to clock
module ppip_edge (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic level_n,
    output logic fall
);
    logic prev_reg;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= level_n;
        end
    end

    assign fall = prev_reg & ~level_n;
endmodule

// [rtl/ppip_port.sv]
// Summary of operation
// - A falling edge of host_strobe_n latches the parallel data byte into the holding register.
// - After a capture hold_off_n goes to the busy state (low).
// - After a capture byte_received_n is asserted low toward the processor.
// - While cpu_read_n is low the held byte appears on the processor data bus.
// - When the byte is consumed, busy is released and next_byte_ack_n is pulsed.
// - While buffer_full is high, busy stays asserted and the acknowledge is withheld.
// - A falling edge of host_init_n starts initialization as power-on does, except that cpu_reset_n is not asserted.
// - A host-requested initialization only drives peripheral_reset_n, not the processor.
// - Power-on reset asserts the processor reset and resets the whole port.
// - After initialization an ack_pulse is sent, serial busy cleared and online_lamp lit.
module ppip_port
    import ppip_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic power_on_reset_n,
    input wire logic [ppip_pkg::PPIP_DATA_W-1:0] host_data,
    input wire logic host_strobe_n,
    input wire logic host_init_n,
    input wire logic cpu_read_n,
    input wire logic buffer_full,
    input wire logic init_done,
    output logic hold_off_n,
    output logic byte_received_n,
    output logic next_byte_ack_n,
    output logic [ppip_pkg::PPIP_DATA_W-1:0] cpu_data,
    output logic cpu_data_oe,
    output logic cpu_reset_n,
    output logic peripheral_reset_n,
    output logic ack_pulse,
    output logic serial_busy_n,
    output logic online_lamp
);
    logic rst_n;
    logic strobe_fall;
    logic init_fall;
    logic read_rise;
    logic rd_prev_reg;
    logic init_busy_reg;
    logic [PPIP_DATA_W-1:0] hold_reg;
    logic [PPIP_CNT_W-1:0] cnt_reg;
    ppip_state_e state_reg;
    logic init_hold;
    logic take_byte;
    logic start_ack;
    logic ack_end;

    assign rst_n = reset_n & power_on_reset_n;
    assign read_rise = ~rd_prev_reg & cpu_read_n;

    // Initialization overrides the host handshake
    assign init_hold = init_busy_reg | init_fall;
    assign take_byte = strobe_fall & (state_reg == PPIP_IDLE) & ~init_hold;
    // Ack is withheld until the processor has room again
    assign start_ack = (state_reg == PPIP_FULL) & (read_rise | byte_received_n) & ~buffer_full
        & ~init_hold;
    assign ack_end = (state_reg == PPIP_ACK) & (cnt_reg == '0);

    ppip_edge u_strobe (
        .clock(clock),
        .reset_n(rst_n),
        .level_n(host_strobe_n),
        .fall(strobe_fall)
    );

    ppip_edge u_init (
        .clock(clock),
        .reset_n(rst_n),
        .level_n(host_init_n),
        .fall(init_fall)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_prev_reg <= 1'b1;
        end else begin
            rd_prev_reg <= cpu_read_n;
        end
    end

    // Processor reset follows reset_n and power_on_reset_n only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cpu_reset_n <= 1'b0;
        end else begin
            cpu_reset_n <= 1'b1;
        end
    end

    // Initialization: held until the processor reports completion
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            init_busy_reg <= 1'b1;
            peripheral_reset_n <= 1'b0;
        end else if (init_fall) begin
            init_busy_reg <= 1'b1;
            peripheral_reset_n <= 1'b0;
        end else begin
            peripheral_reset_n <= 1'b1;
            if (init_done) begin
                init_busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hold_reg <= PPIP_DATA_RST;
        end else if (strobe_fall && state_reg == PPIP_IDLE && !init_busy_reg) begin
            hold_reg <= host_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cpu_data <= PPIP_DATA_RST;
        end else begin
            cpu_data <= hold_reg;
        end
    end

    // Bus enable lags the read strobe by one clock
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cpu_data_oe <= 1'b0;
        end else begin
            cpu_data_oe <= ~cpu_read_n;
        end
    end

    // Handshake toward the host
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= PPIP_IDLE;
        end else if (init_hold) begin
            state_reg <= PPIP_IDLE;
        end else begin
            unique case (state_reg)
                PPIP_IDLE: begin
                    if (take_byte) begin
                        state_reg <= PPIP_FULL;
                    end
                end
                PPIP_FULL: begin
                    if (start_ack) begin
                        state_reg <= PPIP_ACK;
                    end
                end
                PPIP_ACK: begin
                    if (ack_end) begin
                        state_reg <= PPIP_IDLE;
                    end
                end
                default: state_reg <= PPIP_IDLE;
            endcase
        end
    end

    // Ack width counter, idles at zero
    always_ff @(posedge clock) begin
        if (!rst_n || init_hold) begin
            cnt_reg <= '0;
        end else if (start_ack) begin
            cnt_reg <= PPIP_CNT_W'(PPIP_ACK_CYC - 1);
        end else if (state_reg == PPIP_ACK && !ack_end) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || init_hold) begin
            hold_off_n <= 1'b0;
        end else if (take_byte) begin
            hold_off_n <= 1'b0;
        end else if (start_ack) begin
            hold_off_n <= 1'b1;
        end else if (state_reg == PPIP_IDLE) begin
            hold_off_n <= ~buffer_full;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || init_hold) begin
            byte_received_n <= 1'b1;
        end else if (take_byte) begin
            byte_received_n <= 1'b0;
        end else if (state_reg == PPIP_FULL && read_rise) begin
            byte_received_n <= 1'b1;
        end
    end

    // Held low for the whole pulse width
    always_ff @(posedge clock) begin
        if (!rst_n || init_hold) begin
            next_byte_ack_n <= 1'b1;
        end else if (start_ack) begin
            next_byte_ack_n <= 1'b0;
        end else if (ack_end) begin
            next_byte_ack_n <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || init_fall) begin
            ack_pulse <= 1'b0;
        end else begin
            ack_pulse <= init_busy_reg & init_done;
        end
    end

    // Online indication after initialization
    always_ff @(posedge clock) begin
        if (!rst_n || init_fall) begin
            serial_busy_n <= 1'b0;
            online_lamp <= 1'b0;
        end else if (init_busy_reg && init_done) begin
            serial_busy_n <= 1'b1;
            online_lamp <= 1'b1;
        end
    end
endmodule

// [test/ppip_port_sva.sv]
module ppip_port_sva
    import ppip_pkg::*;
(
    input logic clock,
    input logic reset_n,
    input logic power_on_reset_n,
    input logic host_strobe_n,
    input logic host_init_n,
    input logic cpu_read_n,
    input logic buffer_full,
    input logic init_done,
    input logic hold_off_n,
    input logic byte_received_n,
    input logic next_byte_ack_n,
    input logic cpu_data_oe,
    input logic cpu_reset_n,
    input logic peripheral_reset_n,
    input logic ack_pulse,
    input logic serial_busy_n,
    input logic online_lamp
);
    logic [PPIP_CNT_W-1:0] ack_cnt_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (!(reset_n && power_on_reset_n));
    // Counts low cycles of the acknowledge; clears itself while it is high
    always_ff @(posedge clock) begin
        ack_cnt_reg <= next_byte_ack_n ? 10'h000 : ack_cnt_reg + 10'h001;
    end
    a_strobe_busy: assert property ($fell(host_strobe_n) && hold_off_n && next_byte_ack_n &&
        online_lamp |=> !hold_off_n && !byte_received_n) else $error("strobe not taken");
    a_read_oe: assert property (!cpu_read_n ##1 !cpu_read_n |-> cpu_data_oe)
        else $error("read data not driven");
    a_read_off: assert property (cpu_read_n |=> !cpu_data_oe) else $error("bus driven idle");
    a_full_hold: assert property (buffer_full && !hold_off_n |=>
        !hold_off_n && next_byte_ack_n) else $error("busy dropped while full");
    // A host prime cuts the pulse short; serial busy marks that case
    a_ack_width: assert property ($rose(next_byte_ack_n) && serial_busy_n |->
        ack_cnt_reg == PPIP_ACK_CYC) else $error("ack width wrong");
    a_ack_release: assert property ($fell(next_byte_ack_n) |-> $rose(hold_off_n) &&
        byte_received_n) else $error("ack without release");
    a_prime_reset: assert property ($fell(host_init_n) |=> !peripheral_reset_n && cpu_reset_n
        ##1 peripheral_reset_n) else $error("prime reset wrong");
    a_init_done: assert property (!online_lamp && init_done |=> ack_pulse && online_lamp &&
        serial_busy_n ##1 !ack_pulse) else $error("init completion wrong");
    a_power_reset: assert property (disable iff (1'b0) !power_on_reset_n |=> !cpu_reset_n &&
        !peripheral_reset_n && !hold_off_n) else $error("power reset wrong");
    cover property ($fell(next_byte_ack_n));
    cover property (!byte_received_n && buffer_full);
    cover property ($fell(host_init_n));
endmodule
bind ppip_port ppip_port_sva u_sva (.*);

// [test/ppip_host.sv]
module ppip_host (
    input wire logic clock,
    input wire logic hold_off_n,
    input wire logic next_byte_ack_n,
    output logic [7:0] host_data,
    output logic host_strobe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        host_strobe_n = 1;
        host_data = 8'h00;
    end
    task send(input logic [7:0] b);
        while (hold_off_n !== 1 || next_byte_ack_n !== 1) @(negedge clock);
        host_data = b;
        @(negedge clock) host_strobe_n = 0;
        repeat (2) @(negedge clock);
        host_strobe_n = 1;
        // Released data must not look valid
        host_data = ~b;
    endtask
endmodule

// [test/printer_parallel_input_port_test.sv]
module printer_parallel_input_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ppip_pkg::*;
    logic clock = 0, reset_n = 0, power_on_reset_n = 0, host_init_n = 1;
    logic cpu_read_n = 1, buffer_full = 0, init_done = 0, oe_d = 0;
    logic hold_off_n, byte_received_n, next_byte_ack_n, cpu_data_oe, cpu_reset_n;
    logic peripheral_reset_n, ack_pulse, serial_busy_n, online_lamp, host_strobe_n;
    logic [PPIP_DATA_W-1:0] host_data, cpu_data, b, q[$];
    int error_cnt = 0, n_compared = 0;
    always #5 clock = ~clock;
    ppip_port uut (.*);
    ppip_host host (.*);
    task check(input logic [7:0] seen, input logic [7:0] exp, input string name);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task pulse_done;
        @(negedge clock) init_done = 1;
        @(negedge clock) init_done = 0;
        check(ack_pulse, 1, "ack_pulse");
    endtask
    task traffic(input int n);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            q.push_back(b);
            host.send(b);
        end
        for (int i = 0; i < 3000 && (q.size() > 0 || next_byte_ack_n !== 1); i++) @(negedge clock);
        check(8'(q.size()), 8'h00, "bytes_unread");
        check(next_byte_ack_n, 1, "next_byte_ack_n");
    endtask
    initial begin
        #300us;
        error_cnt++;
        give_verdict;
    end
    // Processor side: reads each byte, sometimes claiming a full buffer
    initial forever begin
        @(negedge clock);
        if (byte_received_n === 0) begin
            buffer_full = 1'($urandom % 2);
            repeat ($urandom % 4) @(negedge clock);
            cpu_read_n = 0;
            repeat (3) @(negedge clock);
            cpu_read_n = 1;
            repeat (3) @(negedge clock);
            buffer_full = 0;
        end
    end
    always @(negedge clock) begin
        if (cpu_data_oe === 1 && oe_d !== 1) check(cpu_data, q.pop_front(), "cpu_data");
        oe_d = cpu_data_oe;
    end
    initial begin
        void'($urandom(63771));
        repeat (4) @(negedge clock);
        reset_n = 1;
        power_on_reset_n = 1;
        @(negedge clock) check(cpu_reset_n, 1, "cpu_reset_n");
        pulse_done;
        traffic(6);
        @(negedge clock) host_init_n = 0;
        @(negedge clock) host_init_n = 1;
        check(online_lamp, 0, "online_lamp");
        check(cpu_reset_n, 1, "cpu_reset_n");
        check(peripheral_reset_n, 0, "peripheral_reset_n");
        pulse_done;
        check(online_lamp, 1, "online_lamp");
        check(serial_busy_n, 1, "serial_busy_n");
        @(negedge clock) power_on_reset_n = 0;
        @(negedge clock) check(cpu_reset_n, 0, "cpu_reset_n");
        check(hold_off_n, 0, "hold_off_n");
        check(online_lamp, 0, "online_lamp");
        power_on_reset_n = 1;
        pulse_done;
        traffic(3);
        give_verdict;
    end
endmodule
